// file: irqm_defs.vh
// Overview of operation
// RULE_01 - monitor bits 7-4 show GPI pin levels
// RULE_02 - config bit 7 picks alert polarity
// RULE_03 - mode 0: level while unmasked latch present
// RULE_04 - mode 2: 2 ms every 4 ms
// RULE_05 - mode 3: one 2 ms pulse per event
// RULE_06 - config bit 2 hides masked latch bits
// RULE_07 - mask bit 7 gates clock error, resets 1
// RULE_08 - mask bit 6 gates PLL lock, resets 1
// RULE_09 - latch bit 7 records clock error
// RULE_10 - latch bit 6 records PLL lock
// RULE_11 - reading latch register clears its bits; with config bit 2 set, masked bits stay latched
// RULE_12 - masked sources latch but never alert
`ifndef IRQM_DEFS_VH
`define IRQM_DEFS_VH

// register offsets on the control port
`define IRQM_ADDR_MONITOR 8'h2F
`define IRQM_ADDR_CONFIG  8'h32
`define IRQM_ADDR_MASK    8'h33
`define IRQM_ADDR_LATCH   8'h36

// field positions
`define IRQM_CFG_POL      7
`define IRQM_CFG_MODE_HI  6
`define IRQM_CFG_MODE_LO  5
`define IRQM_CFG_VIS      2
`define IRQM_SRC_CLKERR   7
`define IRQM_SRC_PLL      6
`define IRQM_MON_LO       4

// reset values
`define IRQM_RST_CONFIG   8'h00
`define IRQM_RST_MASK     8'hFF
`define IRQM_RST_BYTE     8'h00

// alert modes
`define IRQM_MODE_LEVEL   2'h0
`define IRQM_MODE_RSVD    2'h1
`define IRQM_MODE_REPEAT  2'h2
`define IRQM_MODE_SINGLE  2'h3

// timing, in ns
`define IRQM_CLK_NS       20
`define IRQM_PULSE_NS     2000000
`define IRQM_PERIOD_NS    4000000

`endif

// file: irqm_alert_monitor.v
`timescale 1ns/1ps
`default_nettype none
`include "irqm_defs.vh"

module irqm_alert_monitor #(
  parameter integer PULSE_CYC  = `IRQM_PULSE_NS / `IRQM_CLK_NS,
  parameter integer PERIOD_CYC = `IRQM_PERIOD_NS / `IRQM_CLK_NS,
  parameter integer CNT_W      = 18
) (
  input  wire       mclk,
  input  wire       rst_b,
  input  wire [7:0] regAddr,
  input  wire       regWrEn,
  input  wire [7:0] regWrData,
  input  wire       regRdEn,
  output reg  [7:0] regRdData_q,
  input  wire [3:0] pinLevel,
  input  wire [3:0] pinIsGpi,
  input  wire       clkErrEvent,
  input  wire       pllLockEvent,
  output reg        alertPin_q
);

  // integer forms first, then cut to the counter width on purpose
  localparam integer     PULSE_LAST_I  = PULSE_CYC - 1;
  localparam integer     PERIOD_LAST_I = PERIOD_CYC - 1;
  localparam integer     PULSE_LEN_I   = PULSE_CYC;
  localparam [CNT_W-1:0] PULSE_LAST    = PULSE_LAST_I[CNT_W-1:0];
  localparam [CNT_W-1:0] PERIOD_LAST   = PERIOD_LAST_I[CNT_W-1:0];
  localparam [CNT_W-1:0] PULSE_LEN     = PULSE_LEN_I[CNT_W-1:0];

  // latched bits as seen by software, given visibility mode
  function [7:0] latchView;
    input [7:0] latchByte;
    input [7:0] maskByte;
    input       onlyUnmasked;
    begin
      if (onlyUnmasked) begin
        latchView = latchByte & ~maskByte;
      end else begin
        latchView = latchByte;
      end
    end
  endfunction

  reg  [7:0]       config_q;
  reg  [7:0]       mask_q;
  reg  [7:0]       latch_q;
  reg  [7:0]       latch_d;
  reg  [CNT_W-1:0] periodCnt_q;
  reg  [CNT_W-1:0] periodCnt_d;
  reg  [CNT_W-1:0] pulseCnt_q;
  reg  [CNT_W-1:0] pulseCnt_d;
  reg              alertPin_d;
  reg  [7:0]       rdData_d;
  reg              asserted;
  wire [7:0]       eventByte;
  wire [7:0]       monitorByte;
  wire [7:0]       visibleLatch;
  wire [1:0]       alertMode;
  wire             anyPending;
  wire             newEvent;
  wire             latchRead;

  assign alertMode = config_q[`IRQM_CFG_MODE_HI:`IRQM_CFG_MODE_LO];
  assign latchRead = regRdEn && (regAddr == `IRQM_ADDR_LATCH);

  // map the two sources onto their byte positions
  assign eventByte[`IRQM_SRC_CLKERR] = clkErrEvent;  // RULE_09
  assign eventByte[`IRQM_SRC_PLL]    = pllLockEvent; // RULE_10
  assign eventByte[`IRQM_SRC_PLL-1:0] = 6'h00;

  // pin one lands on bit 7, pin four on bit 4; non-GPI pins read 0
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gMon
      assign monitorByte[`IRQM_SRC_CLKERR-g] = pinLevel[g] & pinIsGpi[g]; // RULE_01
    end
  endgenerate
  assign monitorByte[`IRQM_MON_LO-1:0] = 4'h0; // RULE_01

  assign visibleLatch = latchView(latch_q, mask_q, config_q[`IRQM_CFG_VIS]); // RULE_06

  // masked sources never reach the alert logic
  assign anyPending = |(latch_q & ~mask_q);   // RULE_07 RULE_08 RULE_12
  assign newEvent   = |(eventByte & ~mask_q); // RULE_12

  // latch update: reading clears what was shown, a new event wins
  always @* begin
    latch_d = latch_q;
    if (latchRead) begin
      latch_d = latch_q & ~visibleLatch; // RULE_11
    end
    latch_d = latch_d | eventByte; // RULE_09 RULE_10 RULE_12
  end

  // read mux; unmapped offsets read zero, reserved bits zero
  always @* begin
    case (regAddr)
      `IRQM_ADDR_MONITOR: rdData_d = monitorByte; // RULE_01
      `IRQM_ADDR_CONFIG:  rdData_d = config_q;
      `IRQM_ADDR_MASK:    rdData_d = mask_q;
      `IRQM_ADDR_LATCH:   rdData_d = visibleLatch; // RULE_06
      default:            rdData_d = `IRQM_RST_BYTE;
    endcase
  end

  // repeat-mode phase counter; parks on the last phase while idle so the
  // first pending cycle lands on phase 0 and the first pulse is full width
  always @* begin
    periodCnt_d = periodCnt_q;
    if (!anyPending || alertMode != `IRQM_MODE_REPEAT) begin
      periodCnt_d = PERIOD_LAST; // RULE_04
    end else if (periodCnt_q == PERIOD_LAST) begin
      periodCnt_d = {CNT_W{1'b0}}; // RULE_04
    end else begin
      periodCnt_d = periodCnt_q + 1'b1;
    end
  end

  // single-pulse timer; a fresh event restarts the full width
  always @* begin
    pulseCnt_d = pulseCnt_q;
    if (alertMode != `IRQM_MODE_SINGLE) begin
      pulseCnt_d = {CNT_W{1'b0}};
    end else if (newEvent) begin
      pulseCnt_d = PULSE_LEN; // RULE_05
    end else if (pulseCnt_q != {CNT_W{1'b0}}) begin
      pulseCnt_d = pulseCnt_q - 1'b1;
    end
  end

  // mode select, then polarity; reserved mode keeps the pin idle
  always @* begin
    case (alertMode)
      `IRQM_MODE_LEVEL:  asserted = anyPending; // RULE_03
      `IRQM_MODE_REPEAT: asserted = anyPending && (periodCnt_d <= PULSE_LAST); // RULE_04
      `IRQM_MODE_SINGLE: asserted = (pulseCnt_d != {CNT_W{1'b0}}); // RULE_05
      default:           asserted = 1'b0; // RULE_03
    endcase
    if (config_q[`IRQM_CFG_POL]) begin
      alertPin_d = asserted; // RULE_02
    end else begin
      alertPin_d = ~asserted; // RULE_02
    end
  end

  // register file writes; reserved config bits never stored
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      config_q <= `IRQM_RST_CONFIG;
      mask_q   <= `IRQM_RST_MASK; // RULE_07 RULE_08
    end else if (regWrEn) begin
      if (regAddr == `IRQM_ADDR_CONFIG) begin
        config_q <= {regWrData[`IRQM_CFG_POL:`IRQM_CFG_MODE_LO], 2'h0,
                     regWrData[`IRQM_CFG_VIS], 2'h0};
      end
      if (regAddr == `IRQM_ADDR_MASK) begin
        mask_q <= regWrData; // RULE_07 RULE_08
      end
    end
  end

  // state and output flops; pin idles high after reset (active low)
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      latch_q     <= `IRQM_RST_BYTE;
      periodCnt_q <= {CNT_W{1'b0}};
      pulseCnt_q  <= {CNT_W{1'b0}};
      regRdData_q <= `IRQM_RST_BYTE;
      alertPin_q  <= 1'b1;
    end else begin
      latch_q     <= latch_d;
      periodCnt_q <= periodCnt_d;
      pulseCnt_q  <= pulseCnt_d;
      alertPin_q  <= alertPin_d;
      if (regRdEn) begin
        regRdData_q <= rdData_d; // data holds until the next read
      end
    end
  end

endmodule // irqm_alert_monitor

`default_nettype wire

// file: irqm_alert_monitor_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module irqm_alert_monitor_asserts (
  input wire logic       mclk, rst_b, regWrEn, regRdEn, clkErrEvent, alertPin_q,
  input wire logic [7:0] regAddr, regWrData, regRdData_q,
  input wire logic [3:0] pinLevel, pinIsGpi
);
  logic [7:0] cfg_q, msk_q;
  wire logic [3:0] mv = {<<{pinLevel & pinIsGpi}};
  wire logic rdL = regRdEn && regAddr == 8'h36;
  // shadow of config and mask, so alert checks know mode and masking
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) {cfg_q, msk_q} <= 16'h00FF;
    else if (regWrEn && regAddr == 8'h32) cfg_q <= regWrData & 8'hE4;
    else if (regWrEn && regAddr == 8'h33) msk_q <= regWrData;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_cfg_read: assert property (regRdEn && regAddr == 8'h32 |=>
    regRdData_q == $past(cfg_q)) else $error("config readback");
  a_mask_read: assert property (regRdEn && regAddr == 8'h33 |=>
    regRdData_q == $past(msk_q)) else $error("mask readback");
  a_mon_read: assert property (regRdEn && regAddr == 8'h2F |=>
    regRdData_q == {$past(mv), 4'h0}) else $error("monitor readback");
  a_latch_rsvd: assert property (rdL |=> regRdData_q[5:0] == 6'h00)
    else $error("latch low bits set");
  a_read_hold: assert property (!regRdEn |=> $stable(regRdData_q)) else $error("read data moved");
  a_latch_clear: assert property ((rdL && !clkErrEvent && !regWrEn) ##1 !(clkErrEvent || regWrEn)
    ##1 rdL |=> !regRdData_q[7]) else $error("latch not cleared");
  a_masked_idle: assert property ($past(msk_q[7:6]) == 2'h3 && $past(cfg_q[6:5]) != 2'h3
    |-> alertPin_q == !$past(cfg_q[7])) else $error("masked alert");
  a_rsvd_idle: assert property ($past(cfg_q[6:5]) == 2'h1 |->
    alertPin_q == !$past(cfg_q[7])) else $error("reserved mode alert");
endmodule // irqm_alert_monitor_asserts
bind irqm_alert_monitor irqm_alert_monitor_asserts irqm_alert_monitor_asserts_i (.mclk, .rst_b,
  .regWrEn, .regRdEn, .clkErrEvent, .alertPin_q, .regAddr, .regWrData, .regRdData_q,
  .pinLevel, .pinIsGpi);
`default_nettype wire

// file: irqm_host.sv
`timescale 1ns/1ps
`default_nettype none
module irqm_host (
  input  wire logic       mclk,
  input  wire logic [7:0] regRdData_q,
  output var  logic [7:0] regAddr = 8'h00, regWrData = 8'h00,
  output var  logic       regWrEn = 1'b0, regRdEn = 1'b0
);
  // strobe held across one edge; an idle cycle between calls avoids double drives
  task wr(input logic [7:0] a, dat);
    @(posedge mclk); #1 {regAddr, regWrData, regWrEn} = {a, dat, 1'b1};
    @(posedge mclk); #1 regWrEn = 1'b0;
  endtask
  // reading the latch register is how the host releases a level alert
  task rd(input logic [7:0] a, output logic [7:0] dat);
    @(posedge mclk); #1 {regAddr, regRdEn} = {a, 1'b1};
    @(posedge mclk); #1 dat = regRdData_q;
    regRdEn = 1'b0;
  endtask
endmodule // irqm_host
`default_nettype wire

// file: irq_config_and_input_monitor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module irq_config_and_input_monitor_tb_top;
  logic mclk = 0, rst_b = 0, clkErrEvent = 0, pllLockEvent = 0;
  logic [3:0] pinLevel = 4'h5, pinIsGpi = 4'h7;
  wire logic [7:0] regAddr, regWrData, regRdData_q;
  wire logic regWrEn, regRdEn, alertPin_q;
  logic [7:0] d;
  int bad_count = 0, check_count = 0;
  logic [7:0] k;
  always #10 mclk = ~mclk;
  irqm_alert_monitor #(.PULSE_CYC(4), .PERIOD_CYC(8)) irqm_alert_monitor_i (.mclk, .rst_b,
    .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData_q, .pinLevel, .pinIsGpi,
    .clkErrEvent, .pllLockEvent, .alertPin_q);
  irqm_host irqm_host_i (.mclk, .regRdData_q, .regAddr, .regWrData, .regWrEn, .regRdEn);
  task chk(input logic [7:0] g, e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task rdc(input logic [7:0] a, e);
    irqm_host_i.rd(a, d);
    chk(d, e);
  endtask
  task step;
    @(posedge mclk); #1;
  endtask
  // one-cycle event, c picks clock error over lock
  task ev(input bit c);
    @(posedge mclk); #1 {clkErrEvent, pllLockEvent} = {c, !c};
    @(posedge mclk); #1 {clkErrEvent, pllLockEvent} = 2'b00;
  endtask
  // count active-high alert cycles over a window
  task cnt(input int n);
    k = 8'h00;
    repeat (n) begin step; k += (alertPin_q === 1'b1); end
  endtask
  task conclude;
    $display("mismatches %0d checks %0d", bad_count, check_count);
    if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog: the sequence needs well under 500 cycles
  initial begin
    #100000 bad_count++;
    conclude;
  end
  initial begin
    repeat (10) @(posedge mclk);
    #1 rst_b = 1;
    rdc(8'h33, 8'hFF);
    rdc(8'h32, 8'h00);
    rdc(8'h10, 8'h00);
    rdc(8'h2F, 8'hA0);
    irqm_host_i.wr(8'h32, 8'hFF);
    rdc(8'h32, 8'hE4);
    irqm_host_i.wr(8'h32, 8'h00);
    ev(1); step; chk({7'h00, alertPin_q}, 8'h01);
    rdc(8'h36, 8'h80);
    rdc(8'h36, 8'h00);
    irqm_host_i.wr(8'h32, 8'h04);
    ev(0); rdc(8'h36, 8'h00);
    irqm_host_i.wr(8'h32, 8'h00);
    rdc(8'h36, 8'h40);
    irqm_host_i.wr(8'h33, 8'h3F);
    ev(1); step; chk({7'h00, alertPin_q}, 8'h00);
    irqm_host_i.wr(8'h32, 8'hA0);
    step; chk({7'h00, alertPin_q}, 8'h00);
    irqm_host_i.wr(8'h32, 8'h00);
    rdc(8'h36, 8'h80); step; chk({7'h00, alertPin_q}, 8'h01);
    irqm_host_i.wr(8'h32, 8'hC0);
    ev(0); step; cnt(16); chk(k, 8'h08);
    rdc(8'h36, 8'h40);
    irqm_host_i.wr(8'h32, 8'hE0);
    // pulse starts at the edge that takes the event: first cycle seen here
    ev(1); chk({7'h00, alertPin_q}, 8'h01);
    cnt(10); chk(k, 8'h03);
    conclude;
  end
endmodule // irq_config_and_input_monitor_tb_top
`default_nettype wire
